// ==== src/bcc_counter.sv ====
// Seconds to year BCD clock calendar counter with access hold
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Carries are withheld during a host access and applied when it ends.
// - Seconds and minutes count BCD 00 to 59, carrying upward on wrap.
// - Writing seconds clears the 512 Hz to 1 Hz prescaler stages.
// - Hours count BCD 00 to 23, advancing on minutes carry.
// - Weekday one-hot bits 0..6 rotate left per hours carry, 40h to 01h.
// - Weekday gives no carry and is independent of the calendar.
// - Date counts 1 to month length: 31, 30, 28 or leap 29.
// - Month counts BCD 1 to 12, advancing on date carry.
// - Year counts BCD 00 to 99, advancing on month carry.
// - Device itself decides leap years for February length.
// - Stop bit set halts every time and calendar count; host register writes still take effect.
module bcc_counter #(
    parameter int TICK_DIV = bcc_pkg::TICK512_DIV
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             resetn_i,
    input  wire logic             ce_i,
    // Host register access
    input  wire logic             access_active_i,
    input  wire logic             req_valid_i,
    input  wire bcc_pkg::bcc_req_t req_i,
    // Control
    input  wire logic             stop_i,
    // Register outputs
    output logic [7:0]            rdata_o,
    output logic                  rvalid_o,
    output bcc_pkg::bcc_time_t    time_o,
    output logic                  tick_1hz_o
);

    // ************************************************************
    // Prescaler: clock to 512 Hz, then nine binary stages to 1 Hz
    // ************************************************************
    logic [31:0] div_cnt;
    logic [8:0]  subsec;
    logic        pending;
    logic [7:0]  sec, min, hr, dt, mon, yr;
    logic [6:0]  wk;

    wire wr_en   = ce_i && req_valid_i && req_i.wr;
    wire rd_en   = ce_i && req_valid_i && !req_i.wr;
    wire wr_sec  = wr_en && (req_i.addr == bcc_pkg::OFF_SECONDS);
    wire wr_min  = wr_en && (req_i.addr == bcc_pkg::OFF_MINUTES);
    wire wr_hr   = wr_en && (req_i.addr == bcc_pkg::OFF_HOURS);
    wire wr_wk   = wr_en && (req_i.addr == bcc_pkg::OFF_WEEKDAY);
    wire wr_dt   = wr_en && (req_i.addr == bcc_pkg::OFF_DATE);
    wire wr_mon  = wr_en && (req_i.addr == bcc_pkg::OFF_MONTH);
    wire wr_yr   = wr_en && (req_i.addr == bcc_pkg::OFF_YEAR);

    wire tick512 = (div_cnt == 32'(TICK_DIV - 1));
    wire sec_due = tick512 && (subsec == 9'h1FF);

    // Halting also stops the prescaler so no second is lost on resume
    wire run     = ce_i && !stop_i;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_cnt <= 32'h0;
            subsec  <= 9'h000;
        end else if (ce_i && wr_sec) begin
            div_cnt <= 32'h0;
            subsec  <= 9'h000;
        end else if (run) begin
            div_cnt <= tick512 ? 32'h0 : div_cnt + 32'h1;
            if (tick512) begin
                subsec <= subsec + 9'h001;
            end
        end
    end

    // ************************************************************
    // Pending carry held while the host is in a transaction
    // ************************************************************
    // A seconds write restarts the second, so a carry due then is dropped
    wire apply = run && !access_active_i && !wr_sec &&
                 (pending || sec_due);

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pending <= 1'b0;
        end else if (ce_i) begin
            if (wr_sec) begin
                pending <= 1'b0;
            end else if (run && access_active_i && sec_due) begin
                pending <= 1'b1;
            end else if (apply) begin
                pending <= 1'b0;
            end
        end
    end

    // ************************************************************
    // BCD increment chain
    // ************************************************************
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0}
                                   : {v[7:4], v[3:0] + 4'h1};
    endfunction

    // Year tens digit even and units 0,4,8 or odd and 2,6 means div by 4
    wire leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                      : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 ||
                         yr[3:0] == 4'h8);

    wire short_mon = (mon == bcc_pkg::MONTH_APR) ||
                     (mon == bcc_pkg::MONTH_JUN) ||
                     (mon == bcc_pkg::MONTH_SEP) ||
                     (mon == bcc_pkg::MONTH_NOV);
    wire [7:0] mon_len = (mon == bcc_pkg::MONTH_FEB)
                       ? (leap ? bcc_pkg::DAYS_29 : bcc_pkg::DAYS_28)
                       : (short_mon ? bcc_pkg::DAYS_30
                                    : bcc_pkg::DAYS_31);

    wire c_sec = apply;
    wire c_min = c_sec && (sec == bcc_pkg::MAX_SEC_MIN);
    wire c_hr  = c_min && (min == bcc_pkg::MAX_SEC_MIN);
    wire c_day = c_hr  && (hr  == bcc_pkg::MAX_HOURS);
    wire c_mon = c_day && (dt  == mon_len);
    wire c_yr  = c_mon && (mon == bcc_pkg::MAX_MONTH);

    wire [7:0] next_sec = (sec == bcc_pkg::MAX_SEC_MIN) ? 8'h00
                                                        : bcd_inc(sec);
    wire [7:0] next_min = (min == bcc_pkg::MAX_SEC_MIN) ? 8'h00
                                                        : bcd_inc(min);
    wire [7:0] next_hr  = (hr == bcc_pkg::MAX_HOURS) ? 8'h00
                                                     : bcd_inc(hr);
    wire [7:0] next_dt  = (dt == mon_len) ? 8'h01 : bcd_inc(dt);
    wire [7:0] next_mon = (mon == bcc_pkg::MAX_MONTH) ? 8'h01
                                                      : bcd_inc(mon);
    wire [7:0] next_yr  = (yr == bcc_pkg::MAX_YEAR) ? 8'h00
                                                    : bcd_inc(yr);
    // Weekday feeds nothing further up the chain
    wire [6:0] next_wk  = (wk == bcc_pkg::WEEK_LAST) ? 7'h01
                                                     : {wk[5:0], 1'b0};

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sec <= bcc_pkg::RST_SECONDS;
            min <= bcc_pkg::RST_MINUTES;
            hr  <= bcc_pkg::RST_HOURS;
            wk  <= bcc_pkg::RST_WEEKDAY;
            dt  <= bcc_pkg::RST_DATE;
            mon <= bcc_pkg::RST_MONTH;
            yr  <= bcc_pkg::RST_YEAR;
        end else if (ce_i) begin
            if (wr_sec) sec <= req_i.wdata;
            else if (c_sec) sec <= next_sec;
            if (wr_min) min <= req_i.wdata;
            else if (c_min) min <= next_min;
            if (wr_hr) hr <= req_i.wdata;
            else if (c_hr) hr <= next_hr;
            if (wr_wk) wk <= req_i.wdata[6:0];
            else if (c_day) wk <= next_wk;
            if (wr_dt) dt <= req_i.wdata;
            else if (c_day) dt <= next_dt;
            if (wr_mon) mon <= req_i.wdata;
            else if (c_mon) mon <= next_mon;
            if (wr_yr) yr <= req_i.wdata;
            else if (c_yr) yr <= next_yr;
        end
    end

    // ************************************************************
    // Read path and mirrors
    // ************************************************************
    wire [7:0] rd_mux = (req_i.addr == bcc_pkg::OFF_SECONDS) ? sec :
                        (req_i.addr == bcc_pkg::OFF_MINUTES) ? min :
                        (req_i.addr == bcc_pkg::OFF_HOURS)   ? hr  :
                        (req_i.addr == bcc_pkg::OFF_WEEKDAY) ? {1'b0, wk} :
                        (req_i.addr == bcc_pkg::OFF_DATE)    ? dt  :
                        (req_i.addr == bcc_pkg::OFF_MONTH)   ? mon :
                        (req_i.addr == bcc_pkg::OFF_YEAR)    ? yr  : 8'h00;

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_o    <= 8'h00;
            rvalid_o   <= 1'b0;
            time_o     <= '{bcc_pkg::RST_SECONDS, bcc_pkg::RST_MINUTES,
                            bcc_pkg::RST_HOURS, bcc_pkg::RST_WEEKDAY,
                            bcc_pkg::RST_DATE, bcc_pkg::RST_MONTH,
                            bcc_pkg::RST_YEAR};
            tick_1hz_o <= 1'b0;
        end else if (ce_i) begin
            rvalid_o   <= rd_en;
            if (rd_en) rdata_o <= rd_mux;
            time_o     <= '{sec, min, hr, wk, dt, mon, yr};
            tick_1hz_o <= apply;
        end
    end

endmodule

`default_nettype wire

// ==== src/bcc_pkg.sv ====
// Constants and carrier types for the BCD clock calendar counter
package bcc_pkg;
    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [7:0] OFF_SECONDS = 8'h10;
    localparam logic [7:0] OFF_MINUTES = 8'h11;
    localparam logic [7:0] OFF_HOURS   = 8'h12;
    localparam logic [7:0] OFF_WEEKDAY = 8'h13;
    localparam logic [7:0] OFF_DATE    = 8'h14;
    localparam logic [7:0] OFF_MONTH   = 8'h15;
    localparam logic [7:0] OFF_YEAR    = 8'h16;

    // ************************************************************
    // Reset values and counting limits
    // ************************************************************
    localparam logic [7:0] RST_SECONDS = 8'h00;
    localparam logic [7:0] RST_MINUTES = 8'h00;
    localparam logic [7:0] RST_HOURS   = 8'h00;
    localparam logic [6:0] RST_WEEKDAY = 7'h01;
    localparam logic [7:0] RST_DATE    = 8'h01;
    localparam logic [7:0] RST_MONTH   = 8'h01;
    localparam logic [7:0] RST_YEAR    = 8'h00;
    localparam logic [7:0] MAX_SEC_MIN = 8'h59;
    localparam logic [7:0] MAX_HOURS   = 8'h23;
    localparam logic [7:0] MAX_MONTH   = 8'h12;
    localparam logic [7:0] MAX_YEAR    = 8'h99;
    localparam logic [7:0] DAYS_31     = 8'h31;
    localparam logic [7:0] DAYS_30     = 8'h30;
    localparam logic [7:0] DAYS_29     = 8'h29;
    localparam logic [7:0] DAYS_28     = 8'h28;
    localparam logic [7:0] MONTH_FEB   = 8'h02;
    localparam logic [7:0] MONTH_APR   = 8'h04;
    localparam logic [7:0] MONTH_JUN   = 8'h06;
    localparam logic [7:0] MONTH_SEP   = 8'h09;
    localparam logic [7:0] MONTH_NOV   = 8'h11;
    localparam logic [6:0] WEEK_LAST   = 7'h40;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_HZ       = 50000000;
    localparam int PRESCALE_HZ  = 512;
    localparam int TICK512_DIV  = CLK_HZ / PRESCALE_HZ;
    localparam int SUBSEC_STAGES = 9;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bcc_req_t;

    typedef struct packed {
        logic [7:0] seconds;
        logic [7:0] minutes;
        logic [7:0] hours;
        logic [6:0] weekday;
        logic [7:0] date;
        logic [7:0] month;
        logic [7:0] year;
    } bcc_time_t;
endpackage

// ==== sim/bcc_counter_checker.sv ====
// Assertion checker for the BCD clock calendar counter
`timescale 1ns/1ps
`default_nettype none
module bcc_counter_checker (
    // Clock, reset and host side
    input wire logic               clk_i,
    input wire logic               resetn_i,
    input wire logic               ce_i,
    input wire logic               access_active_i,
    input wire logic               req_valid_i,
    input wire bcc_pkg::bcc_req_t  req_i,
    input wire logic               stop_i,
    // Counter outputs
    input wire logic               rvalid_o,
    input wire bcc_pkg::bcc_time_t time_o,
    input wire logic               tick_1hz_o
);
    // ********
    // Properties
    // ********
    function automatic logic ok(logic [7:0] v, logic [7:0] lo, logic [7:0] hi);
        return v[3:0] <= 4'h9 && v >= lo && v <= hi;
    endfunction
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    hold_no_tick_a: assert property ($past(ce_i) && tick_1hz_o
        |-> !$past(access_active_i))
        else $error("second applied during access");
    stop_no_tick_a: assert property ($past(ce_i) && tick_1hz_o
        |-> !$past(stop_i))
        else $error("second applied while stopped");
    sec_range_a: assert property (ok(time_o.seconds, 8'h00, 8'h59))
        else $error("seconds out of range");
    min_range_a: assert property (ok(time_o.minutes, 8'h00, 8'h59))
        else $error("minutes out of range");
    hour_range_a: assert property (ok(time_o.hours, 8'h00, 8'h23))
        else $error("hours out of range");
    week_onehot_a: assert property ($onehot(time_o.weekday))
        else $error("weekday not one-hot");
    date_range_a: assert property (ok(time_o.date, 8'h01, 8'h31))
        else $error("date out of range");
    month_range_a: assert property (ok(time_o.month, 8'h01, 8'h12))
        else $error("month out of range");
    year_range_a: assert property (ok(time_o.year, 8'h00, 8'h99))
        else $error("year out of range");
    read_answer_a: assert property (req_valid_i && ce_i && !req_i.wr
        |=> rvalid_o)
        else $error("read got no answer");
    cover property (tick_1hz_o);
    cover property (rvalid_o);
    cover property (stop_i ##1 stop_i);
endmodule
bind bcc_counter bcc_counter_checker u_bcc_counter_checker (
    .clk_i, .resetn_i, .ce_i, .access_active_i, .req_valid_i, .req_i,
    .stop_i, .rvalid_o, .time_o, .tick_1hz_o
);
`default_nettype wire

// ==== sim/bcc_host_model.sv ====
// Host side model issuing register accesses
`timescale 1ns/1ps
`default_nettype none
module bcc_host_model (
    // Clock
    input  wire logic         clk_i,
    // Register access
    output logic              access_active_o,
    output logic              req_valid_o,
    output bcc_pkg::bcc_req_t req_o
);
    // ********
    // Access tasks
    // ********
    initial begin
        access_active_o = 1'b0;
        req_valid_o     = 1'b0;
        req_o           = '0;
    end
    task automatic open_acc(input logic on);
        @(posedge clk_i);
        #1 access_active_o = on;
    endtask
    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        req_valid_o = 1'b1;
        req_o       = '{wr: wr, addr: a, wdata: d};
        @(posedge clk_i);
        #1;
        req_valid_o = 1'b0;
        // Released bus shows junk, never the last value
        req_o       = ~req_o;
    endtask
endmodule
`default_nettype wire

// ==== sim/bcc_counter_tb_top.sv ====
// Self-checking testbench for the BCD clock calendar counter
`timescale 1ns/1ps
`default_nettype none
module bcc_counter_tb_top;
    // ********
    // Bench state
    // ********
    logic               clk_i;
    logic               resetn_i;
    logic               stop_i;
    logic               ce;
    logic               act;
    logic               req_valid;
    logic               rvalid_o;
    logic               tick_1hz_o;
    logic [7:0]         rdata_o;
    bcc_pkg::bcc_req_t  req;
    bcc_pkg::bcc_time_t time_o;
    logic [7:0]         expq[$];
    int                 err_count;
    int                 num_checks;
    int                 seed;
    int                 n;
    // Weekday, date, month, year before and after 23:59:59 rolls over
    logic [31:0] set_tab[6] = '{32'h40280204, 32'h01290204, 32'h02280201,
                                32'h04311299, 32'h08300423, 32'h10280200};
    logic [31:0] exp_tab[6] = '{32'h01290204, 32'h02010304, 32'h04010301,
                                32'h08010100, 32'h10010523, 32'h20290200};
    // Leap and month lengths above
    bcc_counter #(.TICK_DIV(2)) u_bcc_counter (
        .clk_i, .resetn_i, .ce_i(ce), .access_active_i(act),
        .req_valid_i(req_valid), .req_i(req), .stop_i, .rdata_o,
        .rvalid_o, .time_o, .tick_1hz_o
    );
    bcc_host_model u_bcc_host_model (
        .clk_i, .access_active_o(act), .req_valid_o(req_valid), .req_o(req)
    );
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        expq.push_back(exp);
        u_bcc_host_model.acc(1'b0, a, 8'h00);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_bcc_host_model.acc(1'b1, a, d);
    endtask
    // Whole register set in one open access
    task automatic burst(input logic w, input logic [55:0] v);
        u_bcc_host_model.open_acc(1'b1);
        for (int i = 0; i < 7; i++) begin
            if (w) wr(8'(8'h10 + i), v[55-8*i -: 8]);
            else rd(8'(8'h10 + i), v[55-8*i -: 8]);
        end
        u_bcc_host_model.open_acc(1'b0);
    endtask
    task automatic wait_tick;
        int k;
        k = 0;
        while (tick_1hz_o !== 1'b1 && k < 1200) begin
            @(posedge clk_i);
            #2;
            k++;
        end
        if (k >= 1200) err_count++;
    endtask
    task automatic final_report;
        // Reads that never got an answer count as mismatches
        err_count += expq.size();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Results are judged in arrival order, not in the driver
    always @(negedge clk_i) begin
        if (rvalid_o === 1'b1) begin
            if (expq.size() == 0) err_count++;
            else chk(rdata_o, expq.pop_front());
        end
    end
    initial begin
        #(20 * 40000);
        err_count++;
        final_report;
    end
    initial begin
        seed = 32'hB32A;
        err_count = 0;
        num_checks = 0;
        stop_i = 1'b0;
        ce = 1'b1;
        resetn_i = 1'b0;
        repeat (5) @(posedge clk_i);
        #1 resetn_i = 1'b1;
        for (int k = 0; k < 6; k++) begin
            burst(1'b1, {24'h595923, set_tab[k]});
            wait_tick;
            burst(1'b0, {24'h000000, exp_tab[k]});
            chk(time_o.date, exp_tab[k][23:16]);
        end
        n = {$random(seed)} % 59;
        wr(8'h10, 8'(n / 10 * 16 + n % 10));
        repeat (900) @(posedge clk_i);
        rd(8'h10, 8'(n / 10 * 16 + n % 10));
        wait_tick;
        rd(8'h10, 8'((n + 1) / 10 * 16 + (n + 1) % 10));
        burst(1'b1, 56'h30201001010101);
        u_bcc_host_model.open_acc(1'b1);
        repeat (1100) @(posedge clk_i);
        rd(8'h10, 8'h30);
        u_bcc_host_model.open_acc(1'b0);
        wait_tick;
        rd(8'h10, 8'h31);
        stop_i = 1'b1;
        wr(8'h10, 8'h40);
        repeat (1100) @(posedge clk_i);
        rd(8'h10, 8'h40);
        stop_i = 1'b0;
        wr(8'h13, 8'hC0);
        rd(8'h13, 8'h40);
        wr(8'h17, 8'h55);
        rd(8'h17, 8'h00);
        // Enable low must freeze the count without losing the second
        repeat (4) @(posedge clk_i);
        #1 ce = 1'b0;
        repeat (1100) @(posedge clk_i);
        #1;
        chk(time_o.seconds, 8'h40);
        ce = 1'b1;
        wait_tick;
        rd(8'h10, 8'h41);
        // Reset in mid-run brings back the reset values
        repeat (2) @(posedge clk_i);
        #1 resetn_i = 1'b0;
        repeat (2) @(posedge clk_i);
        #1 resetn_i = 1'b1;
        burst(1'b0, 56'h00000001010100);
        chk({1'b0, time_o.weekday}, 8'h01);
        repeat (4) @(posedge clk_i);
        final_report;
    end
endmodule
`default_nettype wire
